/* File: logic/sfp_pkg.sv */
package sfp_pkg;

    // ==========================================
    // clock and timing
    // ==========================================
    localparam int CLK_PERIOD_NS = 100; // core_clk period
    localparam int DEEP_ENTRY_NS = 3000; // deep_sleep_entry_time, longest
    localparam int DEEP_WAKE_NS = 8000; // deep_sleep_wake_time, longest
    localparam int ULTRA_ENTRY_NS = 3000; // ultra_sleep_entry_time, longest
    localparam int ULTRA_EXIT_NS = 70000; // ultra_sleep_exit_time, longest
    localparam int SEL_PULSE_NS = 250; // select_pulse_min_time, least

    // longest times round down, least times round up, never below one cycle
    localparam int DEEP_ENTRY_I = (DEEP_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 :
        DEEP_ENTRY_NS / CLK_PERIOD_NS;
    localparam int DEEP_WAKE_I = (DEEP_WAKE_NS / CLK_PERIOD_NS < 1) ? 1 :
        DEEP_WAKE_NS / CLK_PERIOD_NS;
    localparam int ULTRA_ENTRY_I = (ULTRA_ENTRY_NS / CLK_PERIOD_NS < 1) ? 1 :
        ULTRA_ENTRY_NS / CLK_PERIOD_NS;
    localparam int ULTRA_EXIT_I = (ULTRA_EXIT_NS / CLK_PERIOD_NS < 1) ? 1 :
        ULTRA_EXIT_NS / CLK_PERIOD_NS;
    localparam int SEL_PULSE_I = (SEL_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [11:0] DEEP_ENTRY_CYC = 12'(DEEP_ENTRY_I);
    localparam logic [11:0] DEEP_WAKE_CYC = 12'(DEEP_WAKE_I);
    localparam logic [11:0] ULTRA_ENTRY_CYC = 12'(ULTRA_ENTRY_I);
    localparam logic [11:0] ULTRA_EXIT_CYC = 12'(ULTRA_EXIT_I);
    localparam logic [11:0] SEL_PULSE_CYC = 12'(SEL_PULSE_I);
    localparam logic [11:0] SCK_HALF_CYC = 12'h008; // host half period of sck
    localparam logic [11:0] TMR_ONE = 12'h001; // timer terminal value

    // ==========================================
    // opcodes and reset values
    // ==========================================
    localparam logic [7:0] OP_LEGACY_ID = 8'h15; // legacy_identify_cmd
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_DEEP_WAKE = 8'hAB;
    localparam logic [7:0] OP_ULTRA_SLEEP = 8'h79;
    localparam logic [7:0] OP_WRITE_EN_DEF = 8'h06; // write enable, plain default
    localparam logic [4:0] ID_BITS = 5'h10; // two identification bytes
    localparam logic WEL_RESET = 1'b0;

    // ==========================================
    // power modes, gray along deep sleep entry and exit paths
    // ==========================================
    typedef enum logic [2:0] {
        SFP_STBY = 3'b000,
        SFP_ENT_DEEP = 3'b001,
        SFP_DEEP = 3'b011,
        SFP_WAKE = 3'b010,
        SFP_ENT_ULT = 3'b110,
        SFP_ULT = 3'b111,
        SFP_EXIT_ULT = 3'b101
    } sfp_mode_t;

    // host sequencer states
    typedef enum logic [1:0] {
        SFP_H_IDLE = 2'b00,
        SFP_H_LEAD = 2'b01,
        SFP_H_SHIFT = 2'b11,
        SFP_H_TAIL = 2'b10
    } sfp_hstate_t;

endpackage

/* File: logic/sfp_if.sv */
// ==========================================
// serial link between host and flash end
// ==========================================
interface sfp_if;
    logic cs_n; // select, low active
    logic sck; // serial clock from host
    logic si; // host to device data
    logic hold_n; // pause, low active
    logic wp_n; // write protect, low active
    logic so_out; // device output value
    logic so_oe; // device drives so
    logic so; // resolved serial output line

    // undriven line reads as pulled high
    assign so = so_oe ? so_out : 1'b1;

    modport dev (input cs_n, input sck, input si, input hold_n, input wp_n,
                 output so_out, output so_oe);
    modport host (output cs_n, output sck, output si, output hold_n, output wp_n,
                  input so);
endinterface

/* File: logic/sfp_sync.sv */
// ==========================================
// two flop synchroniser, one per bit
// ==========================================
module sfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // refuse an empty synchroniser at elaboration
    if (W < 1) begin : g_bad_width
        $error("sfp_sync width must be at least one");
    end

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            logic meta_r; // first stage, read only by second
            // two stages per bit
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    meta_r <= INIT[i];
                    q[i] <= INIT[i];
                end else begin
                    meta_r <= d[i];
                    q[i] <= meta_r;
                end
            end
        end
    endgenerate
endmodule

/* File: logic/sfp_dev.sv */
module sfp_dev
    import sfp_pkg::*;
#(
    parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3C, // arbitrary value
    parameter logic [7:0] WREN_OP = OP_WRITE_EN_DEF
) (
    input wire logic core_clk,
    input wire logic resetn,
    sfp_if.dev link,
    input wire logic op_busy,
    output logic standby,
    output logic deep_sleep,
    output logic ultra_sleep,
    output logic write_enable_latch,
    output logic wp_active
);
    // write enable opcode must not collide with a power command
    if (WREN_OP == OP_DEEP_SLEEP || WREN_OP == OP_DEEP_WAKE || WREN_OP == OP_ULTRA_SLEEP)
    begin : g_bad_wren
        $error("bad WREN_OP");
    end

    // ==========================================
    // pin synchronisers and edges
    // ==========================================
    logic [4:0] pins_s; // synced cs_n, sck, si, hold_n, wp_n
    logic cs_act; // select asserted
    logic sck_s; // synced serial clock
    logic si_s; // synced serial input
    logic hold_n_s; // synced pause pin
    logic cs_act_d_r; // select, previous cycle
    logic sck_d_r; // sck, previous cycle
    logic sel_ev; // select just asserted
    logic desel_ev; // select just released
    logic rise_ev; // usable rising sck edge
    logic fall_ev; // usable falling sck edge
    logic hold_r; // pause in effect

    // idle levels: deselected, sck low, si low, no pause, no protect
    sfp_sync #(.W(5), .INIT(5'h13)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .d({link.cs_n, link.sck, link.si, link.hold_n, link.wp_n}),
        .q(pins_s)
    );

    assign cs_act = ~pins_s[4];
    assign sck_s = pins_s[3];
    assign si_s = pins_s[2];
    assign hold_n_s = pins_s[1];
    assign wp_active = ~pins_s[0]; // write protect still followed while paused

    // edge history
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cs_act_d_r <= 1'b0;
            sck_d_r <= 1'b0;
        end else begin
            cs_act_d_r <= cs_act;
            sck_d_r <= sck_s;
        end
    end

    assign sel_ev = cs_act & ~cs_act_d_r;
    assign desel_ev = ~cs_act & cs_act_d_r;
    // sck ignored while paused
    assign rise_ev = cs_act & sck_s & ~sck_d_r & ~hold_r;
    assign fall_ev = cs_act & ~sck_s & sck_d_r & ~hold_r;

    // ==========================================
    // pause tracking
    // ==========================================
    // pause follows the pin only while sck is low
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_r <= 1'b0;
        end else if (!cs_act) begin
            hold_r <= 1'b0; // only selected
        end else if (!sck_s) begin
            hold_r <= ~hold_n_s;
        end
    end

    // ==========================================
    // opcode receive
    // ==========================================
    logic [6:0] sh_r; // partial opcode bits
    logic [2:0] bitcnt_r; // bits mod eight since select
    logic bit_seen_r; // any bit clocked this frame
    logic op_ok_r; // full opcode received
    logic [7:0] op_r; // received opcode
    logic [7:0] op_nxt; // opcode with current bit
    logic frame_ign_r; // whole frame is ignored
    logic aligned; // whole opcode and byte boundary
    sfp_mode_t mode_r; // power mode
    logic [11:0] tmr_r; // mode transition timer

    assign op_nxt = {sh_r, si_s};
    assign aligned = op_ok_r & (bitcnt_r == 3'h0);

    // msb first, count from select
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sh_r <= 7'h00;
            bitcnt_r <= 3'h0;
            bit_seen_r <= 1'b0;
            op_ok_r <= 1'b0;
            op_r <= 8'h00;
        end else if (sel_ev) begin
            bitcnt_r <= 3'h0;
            bit_seen_r <= 1'b0;
            op_ok_r <= 1'b0;
        end else if (rise_ev) begin
            sh_r <= op_nxt[6:0];
            bitcnt_r <= bitcnt_r + 3'h1;
            bit_seen_r <= 1'b1;
            // eighth bit closes the opcode, later bits ignored
            if (bitcnt_r == 3'h7 && !op_ok_r) begin
                op_r <= op_nxt;
                op_ok_r <= 1'b1;
            end
        end
    end

    // frames started outside standby or deep sleep are dropped, unless still selected with no bits seen when the ultra exit time ends
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            frame_ign_r <= 1'b0;
        end else if (sel_ev) begin
            // ultra sleep and its exit time drop the frame
            frame_ign_r <= !(mode_r == SFP_STBY || mode_r == SFP_DEEP);
        end else if (mode_r == SFP_EXIT_ULT && tmr_r == TMR_ONE && cs_act
                     && !bit_seen_r && !link.so_oe) begin
            // waited exit time under select: command goes live
            frame_ign_r <= 1'b0;
        end
    end

    // ==========================================
    // power mode sequencing
    // ==========================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= SFP_STBY; // power cycle gives standby
            tmr_r <= 12'h000;
        end else begin
            unique case (mode_r)
                SFP_STBY: begin
                    // deselect while paused aborts
                    if (desel_ev && !frame_ign_r && !hold_r && !op_busy) begin
                        if (aligned && op_r == OP_DEEP_SLEEP) begin
                            mode_r <= SFP_ENT_DEEP;
                            tmr_r <= DEEP_ENTRY_CYC;
                        end else if (op_ok_r && op_r == OP_ULTRA_SLEEP) begin
                            mode_r <= SFP_ENT_ULT;
                            tmr_r <= ULTRA_ENTRY_CYC;
                        end
                    end
                end
                SFP_ENT_DEEP: begin
                    tmr_r <= tmr_r - TMR_ONE;
                    if (tmr_r == TMR_ONE) mode_r <= SFP_DEEP;
                end
                SFP_DEEP: begin
                    // only a whole aligned wake is heard
                    if (desel_ev && !frame_ign_r && !hold_r && aligned
                        && op_r == OP_DEEP_WAKE) begin
                        mode_r <= SFP_WAKE;
                        tmr_r <= DEEP_WAKE_CYC;
                    end
                end
                SFP_WAKE: begin
                    tmr_r <= tmr_r - TMR_ONE;
                    if (tmr_r == TMR_ONE) mode_r <= SFP_STBY;
                end
                SFP_ENT_ULT: begin
                    tmr_r <= tmr_r - TMR_ONE;
                    if (tmr_r == TMR_ONE) mode_r <= SFP_ULT;
                end
                SFP_ULT: begin
                    // any select starts the exit, bytes ignored
                    if (sel_ev) begin
                        mode_r <= SFP_EXIT_ULT;
                        tmr_r <= ULTRA_EXIT_CYC;
                    end
                end
                SFP_EXIT_ULT: begin
                    tmr_r <= tmr_r - TMR_ONE;
                    if (tmr_r == TMR_ONE) mode_r <= SFP_STBY;
                end
                default: begin
                    mode_r <= SFP_STBY;
                    tmr_r <= 12'h000;
                end
            endcase
        end
    end

    // ==========================================
    // write enable latch
    // ==========================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            write_enable_latch <= WEL_RESET;
        end else if (desel_ev && hold_r) begin
            write_enable_latch <= 1'b0;
        end else if (desel_ev && mode_r == SFP_STBY && !frame_ign_r
                     && aligned && op_r == WREN_OP) begin
            write_enable_latch <= 1'b1;
        end
    end

    // ==========================================
    // legacy identification output
    // ==========================================
    logic [15:0] id_sh_r; // bytes still to send
    logic [4:0] id_left_r; // bits still to send
    logic so_r; // output bit
    logic so_oe_r; // output driven by id read

    // bits change on falling sck, read on rising
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            id_sh_r <= 16'h0000;
            id_left_r <= 5'h00;
            so_r <= 1'b0;
            so_oe_r <= 1'b0;
        end else if (!cs_act) begin
            id_left_r <= 5'h00; // deselect ends the read
            so_oe_r <= 1'b0;
        end else if (rise_ev && bitcnt_r == 3'h7 && !op_ok_r && !frame_ign_r
                     && mode_r == SFP_STBY && op_nxt == OP_LEGACY_ID) begin
            id_sh_r <= {MFR_ID, DEV_CODE};
            id_left_r <= ID_BITS;
        end else if (fall_ev) begin
            if (id_left_r != 5'h00) begin
                so_r <= id_sh_r[15];
                id_sh_r <= {id_sh_r[14:0], 1'b0};
                id_left_r <= id_left_r - 5'h01;
                so_oe_r <= 1'b1;
            end else begin
                so_oe_r <= 1'b0; // float after two bytes
            end
        end
    end

    // floats while paused or deselected
    assign link.so_oe = so_oe_r & cs_act & ~hold_r;
    assign link.so_out = so_r;

    // ==========================================
    // user side status
    // ==========================================
    // busy operation is never gated by pause
    assign standby = (mode_r == SFP_STBY);
    assign deep_sleep = (mode_r == SFP_DEEP);
    assign ultra_sleep = (mode_r == SFP_ULT);
endmodule

/* File: logic/sfp_host.sv */
// ==========================================
// host end: serial master with sck divider
// ==========================================
module sfp_host
    import sfp_pkg::*;
#(
    parameter logic [11:0] SCK_HALF = SCK_HALF_CYC
) (
    input wire logic core_clk,
    input wire logic resetn,
    sfp_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_op,
    input wire logic [7:0] cmd_nbytes,
    input wire logic cmd_lead,
    input wire logic hold_req,
    input wire logic wp_req,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    // device answer needs about six cycles after a falling edge
    if (SCK_HALF < 12'h006) begin : g_bad_half
        $error("SCK_HALF too short for round trip");
    end

    sfp_hstate_t st_r; // sequencer state
    logic [11:0] cnt_r; // lead, half period and gap counter
    logic [10:0] bits_r; // bits left in frame
    logic [7:0] tx_r; // bits to send
    logic [7:0] rx_sh_r; // bits received
    logic [2:0] rx_cnt_r; // received bits mod eight
    logic sck_r; // serial clock out
    logic hold_r; // pause driven to device
    logic so_s; // synced serial output line

    sfp_sync #(.W(1), .INIT(1'b1)) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .d(link.so),
        .q(so_s)
    );

    assign cmd_ready = (st_r == SFP_H_IDLE) && (cnt_r == 12'h000);
    assign link.cs_n = (st_r == SFP_H_IDLE);
    assign link.sck = sck_r;
    assign link.si = tx_r[7]; // msb first
    assign link.hold_n = ~hold_r;
    assign link.wp_n = ~wp_req;

    // pause only changes while sck is low
    // tail keeps counting under pause, so a frame can end paused
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_r <= 1'b0;
        end else if (!sck_r) begin
            hold_r <= hold_req & (st_r == SFP_H_SHIFT || st_r == SFP_H_TAIL);
        end
    end

    // ==========================================
    // frame sequencer and sck divider
    // ==========================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= SFP_H_IDLE;
            cnt_r <= 12'h000;
            bits_r <= 11'h000;
            tx_r <= 8'h00;
            sck_r <= 1'b0;
        end else begin
            unique case (st_r)
                SFP_H_IDLE: begin
                    if (cnt_r != 12'h000) begin
                        cnt_r <= cnt_r - TMR_ONE; // deselect gap
                    end else if (cmd_valid) begin
                        st_r <= SFP_H_LEAD;
                        tx_r <= cmd_op;
                        bits_r <= {cmd_nbytes, 3'h0};
                        // bare pulse, or wait exit before first bit
                        if (cmd_nbytes == 8'h00) cnt_r <= SEL_PULSE_CYC;
                        else if (cmd_lead) cnt_r <= ULTRA_EXIT_CYC;
                        else cnt_r <= SCK_HALF;
                    end
                end
                SFP_H_LEAD: begin
                    cnt_r <= cnt_r - TMR_ONE;
                    if (cnt_r == TMR_ONE) begin
                        st_r <= (bits_r == 11'h000) ? SFP_H_TAIL : SFP_H_SHIFT;
                        cnt_r <= SCK_HALF;
                    end
                end
                SFP_H_SHIFT: begin
                    if (!hold_r) begin
                        cnt_r <= cnt_r - TMR_ONE;
                        if (cnt_r == TMR_ONE) begin
                            cnt_r <= SCK_HALF;
                            sck_r <= ~sck_r;
                            if (sck_r) begin
                                // falling edge: next bit, trailing bytes are zero
                                tx_r <= {tx_r[6:0], 1'b0};
                                bits_r <= bits_r - 11'h001;
                                if (bits_r == 11'h001) st_r <= SFP_H_TAIL;
                            end
                        end
                    end
                end
                SFP_H_TAIL: begin
                    cnt_r <= cnt_r - TMR_ONE;
                    if (cnt_r == TMR_ONE) begin
                        st_r <= SFP_H_IDLE;
                        cnt_r <= SCK_HALF;
                    end
                end
                default: begin
                    st_r <= SFP_H_IDLE;
                    cnt_r <= 12'h000;
                end
            endcase
        end
    end

    // ==========================================
    // receive on rising sck
    // ==========================================
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (st_r == SFP_H_IDLE) begin
                rx_cnt_r <= 3'h0;
            end else if (st_r == SFP_H_SHIFT && !hold_r && !sck_r && cnt_r == TMR_ONE) begin
                rx_sh_r <= {rx_sh_r[6:0], so_s};
                rx_cnt_r <= rx_cnt_r + 3'h1;
                if (rx_cnt_r == 3'h7) begin
                    rx_valid <= 1'b1;
                    rx_byte <= {rx_sh_r[6:0], so_s};
                end
            end
        end
    end
endmodule

/* File: test/sfp_props.sv */
// ======
// link checker
module sfp_props (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic so_out,
    input wire logic so_oe
);
    logic sck_q; // sck one cycle ago
    logic [7:0] rise_r; // sck rises in frame
    // count sck rises while selected
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sck_q <= 1'b0;
            rise_r <= 8'h00;
        end else begin
            sck_q <= sck;
            if (cs_n) rise_r <= 8'h00;
            else if (sck && !sck_q && rise_r != 8'hFF) rise_r <= rise_r + 8'h01;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_idle_float; cs_n [*5] |-> !so_oe; endproperty
    a_idle_float: assert property (p_idle_float) else $error("so driven idle");
    property p_hold_float; (!hold_n && !cs_n && !sck) [*6] |-> !so_oe; endproperty
    a_hold_float: assert property (p_hold_float) else $error("so driven paused");
    property p_sck_idle; cs_n |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck high idle");
    property p_si_stable; sck && $past(sck) |-> $stable(si); endproperty
    a_si_stable: assert property (p_si_stable) else $error("si moved");
    property p_so_stable; sck && $past(sck) && so_oe |-> $stable(so_out); endproperty
    a_so_stable: assert property (p_so_stable) else $error("so moved");
    property p_id_quiet; !cs_n && rise_r < 8'h08 |-> !so_oe; endproperty
    a_id_quiet: assert property (p_id_quiet) else $error("so during opcode");
    property p_id_done; rise_r > 8'h18 |-> !so_oe; endproperty
    a_id_done: assert property (p_id_done) else $error("so after id");
    property p_cs_held; $fell(cs_n) |-> !cs_n [*3]; endproperty
    a_cs_held: assert property (p_cs_held) else $error("short select");
endmodule

/* File: test/serial_flash_power_hold_id_bench.sv */
// ======
// bench: host end facing flash end
module serial_flash_power_hold_id_bench import sfp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] PART = 8'hC3; // arbitrary value
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_lead = 1'b0;
    logic hold_req = 1'b0;
    logic wp_req = 1'b0;
    logic op_busy = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [7:0] cmd_nbytes = 8'h00;
    logic cmd_ready, rx_valid, standby, deep_sleep, ultra_sleep, write_enable_latch, wp_active;
    logic [7:0] rx_byte;
    logic [7:0] rxq[$]; // bytes of last frame
    int errors = 0;
    int checks = 0;
    sfp_if lnk();
    sfp_host u_sfp_host (.core_clk, .resetn, .link(lnk), .cmd_valid, .cmd_ready, .cmd_op,
        .cmd_nbytes, .cmd_lead, .hold_req, .wp_req, .rx_valid, .rx_byte);
    sfp_dev #(.MFR_ID(MAKER), .DEV_CODE(PART)) u_sfp_dev (.core_clk, .resetn, .link(lnk),
        .op_busy, .standby, .deep_sleep, .ultra_sleep, .write_enable_latch, .wp_active);
    sfp_props u_sfp_props (.core_clk, .resetn, .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si),
        .hold_n(lnk.hold_n), .so_out(lnk.so_out), .so_oe(lnk.so_oe));
    always #50 core_clk = ~core_clk;
    // collect received bytes
    always @(negedge core_clk) if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t ns: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one whole frame, bounded waits
    task automatic send(input logic [7:0] op, input logic [7:0] n);
        int i;
        rxq.delete();
        @(negedge core_clk);
        cmd_op = op;
        cmd_nbytes = n;
        cmd_valid = 1'b1;
        i = 0;
        // ready is judged away from the edge that moves it
        while (cmd_ready !== 1'b1 && i < 50) begin
            @(negedge core_clk);
            i++;
        end
        if (i >= 50) begin
            errors++;
            end_of_test();
        end
        @(posedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        do begin
            @(negedge core_clk);
            i++;
        end while (!(lnk.cs_n === 1'b1 && cmd_ready === 1'b1) && i < 3000);
        if (i >= 3000) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic t_id();
        send(OP_LEGACY_ID, 8'h04);
        chk(rxq[0], 8'hFF);
        chk(rxq[1], MAKER);
        chk(rxq[2], PART);
        chk(rxq[3], 8'hFF);
        $display("id test done");
    endtask
    task automatic t_busy();
        op_busy = 1'b1;
        send(OP_DEEP_SLEEP, 8'h01);
        send(OP_ULTRA_SLEEP, 8'h01);
        wt(40);
        chk(standby, 1'b1);
        op_busy = 1'b0;
        $display("busy test done");
    endtask
    task automatic t_deep();
        send(OP_DEEP_SLEEP, 8'h02);
        wt(40);
        chk(deep_sleep, 1'b1);
        send(OP_LEGACY_ID, 8'h03);
        chk(rxq[1], 8'hFF);
        chk(deep_sleep, 1'b1);
        send(OP_DEEP_WAKE, 8'h01);
        wt(100);
        chk(standby, 1'b1);
        $display("deep test done");
    endtask
    task automatic t_ultra();
        send(OP_ULTRA_SLEEP, 8'h02);
        wt(40);
        chk(ultra_sleep, 1'b1);
        send(OP_LEGACY_ID, 8'h03);
        chk(rxq[1], 8'hFF);
        wt(700);
        chk(standby, 1'b1);
        send(OP_ULTRA_SLEEP, 8'h01);
        wt(40);
        send(8'h00, 8'h00);
        send(OP_WRITE_EN_DEF, 8'h01);
        chk(write_enable_latch, 1'b0);
        wt(700);
        chk(standby, 1'b1);
        send(OP_ULTRA_SLEEP, 8'h01);
        wt(40);
        cmd_lead = 1'b1;
        send(OP_LEGACY_ID, 8'h03);
        cmd_lead = 1'b0;
        chk(rxq[1], MAKER);
        chk(standby, 1'b1);
        $display("ultra test done");
    endtask
    task automatic t_hold();
        wp_req = 1'b1;
        send(OP_WRITE_EN_DEF, 8'h01);
        chk(write_enable_latch, 1'b1);
        // pause in the middle of the maker byte, then let it go
        fork
            send(OP_LEGACY_ID, 8'h03);
            begin
                wt(200);
                hold_req = 1'b1;
                wt(50);
                chk(lnk.so_oe, 1'b0);
                chk(lnk.so, 1'b1);
                chk(wp_active, 1'b1);
                wt(50);
                hold_req = 1'b0;
            end
        join
        chk(rxq[1], MAKER);
        chk(rxq[2], PART);
        // pause raised in the tail, so select rises while paused
        fork
            send(OP_WRITE_EN_DEF, 8'h01);
            begin
                wt(140);
                hold_req = 1'b1;
            end
        join
        hold_req = 1'b0;
        wt(10);
        chk(write_enable_latch, 1'b0);
        wp_req = 1'b0;
        $display("hold test done");
    endtask
    task automatic t_reset();
        send(OP_WRITE_EN_DEF, 8'h01);
        send(OP_ULTRA_SLEEP, 8'h01);
        wt(40);
        resetn = 1'b0;
        wt(3);
        resetn = 1'b1;
        wt(2);
        chk(standby, 1'b1);
        chk(write_enable_latch, 1'b0);
        $display("reset test done");
    endtask
    // main sequence
    initial begin
        wt(16);
        resetn = 1'b1;
        t_id();
        t_busy();
        t_deep();
        t_ultra();
        t_hold();
        t_reset();
        end_of_test();
    end
endmodule
